//--- hdl/tbs_sequencer.sv
// The address map and the address-and-strobe port were decided locally.
`default_nettype none
// Trigger, delay, measure and reading-capture sequencer
module tbs_sequencer #(
	parameter int RW         = 24,
	parameter int DEPTH      = 512,
	parameter int AW         = 9,
	parameter int CYC_PER_MS = tbs_pkg::MS_CYCLES
) (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic [7:0]    reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [31:0]   reg_rdata,
	input  wire logic          front_key_press,
	input  wire logic          local_mode,
	input  wire logic          remote_trigger,
	input  wire logic          rear_trigger_input,
	input  wire logic          conv_done,
	input  wire logic [RW-1:0] conv_reading,
	output logic               meas_start,
	output logic               measure_done_output,
	output logic               capture_armed
);
	tbs_pkg::tbs_state_t state_r;
	tbs_pkg::tbs_src_t   src_r;
	tbs_pkg::tbs_func_t  func_r;
	logic [2:0]          range_r;
	logic                fixed_delay_mode_r;
	logic                reading_capture_enable_r;
	logic                run_r;
	logic [12:0]         delay_ms_r;
	logic [9:0]          capture_count_r;
	logic [9:0]          stored_r;
	logic                capturing_r;
	logic [AW-1:0]       buf_idx_r;
	logic [RW-1:0]       buf_rd_data;
	logic signed [RW-1:0] min_r;
	logic signed [RW-1:0] max_r;
	logic signed [63:0]  sum_r;
	logic [63:0]         sq_r;
	logic                rear_s1_r;
	logic                rear_s2_r;
	logic                rear_s3_r;
	logic                rear_fall;
	logic                event_hit;
	logic [31:0]         ms_div_r;
	logic                ms_tick;
	logic [12:0]         dly_left_r;
	logic [12:0]         dly_load;
	logic                count_valid;
	logic                initiate;
	logic                store_en;
	logic                last_store;
	logic signed [RW-1:0] rd_s;
	logic signed [2*RW-1:0] rd_sq;

	// Automatic delay lookup by function and range
	function automatic logic [12:0] auto_delay(input tbs_pkg::tbs_func_t f,
		input logic [2:0] r);
		logic [12:0] d;
		d = tbs_pkg::DLY_DIODE;
		case (f)
			tbs_pkg::dc_voltage_function: begin
				d = (r >= tbs_pkg::DCV_HI_RNG) ? tbs_pkg::DLY_DCV_HI
					: tbs_pkg::DLY_DCV_LO;
			end
			tbs_pkg::ac_voltage_function: d = tbs_pkg::DLY_AC;
			tbs_pkg::ac_current_function: d = tbs_pkg::DLY_AC;
			tbs_pkg::frequency_function:  d = tbs_pkg::DLY_FREQ;
			tbs_pkg::dc_current_function: d = tbs_pkg::DLY_DCI;
			tbs_pkg::res_2wire_function,
			tbs_pkg::res_4wire_function: begin
				case (r)
					3'h0, 3'h1: d = tbs_pkg::DLY_RES_R0;
					3'h2:       d = tbs_pkg::DLY_RES_R2;
					3'h3:       d = tbs_pkg::DLY_RES_R3;
					3'h4:       d = tbs_pkg::DLY_RES_R4;
					3'h5:       d = tbs_pkg::DLY_RES_R5;
					default:    d = tbs_pkg::DLY_RES_R6;
				endcase
			end
			tbs_pkg::continuity_function: d = tbs_pkg::DLY_CONT;
			tbs_pkg::diode_function:      d = tbs_pkg::DLY_DIODE;
			default:                      d = tbs_pkg::DLY_DIODE;
		endcase
		return d;
	endfunction

	// Rear input synchroniser and falling edge detect
	// Stages reset to the idle high level so no false edge follows reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rear_s1_r <= 1'b1;
			rear_s2_r <= 1'b1;
			rear_s3_r <= 1'b1;
		end else begin
			rear_s1_r <= rear_trigger_input;
			rear_s2_r <= rear_s1_r;
			rear_s3_r <= rear_s2_r;
		end
	end
	assign rear_fall = rear_s3_r & ~rear_s2_r;

	// Event detection per selected source
	always_comb begin
		case (src_r)
			tbs_pkg::immediate_source:      event_hit = 1'b1;
			tbs_pkg::front_key_source:      event_hit = front_key_press & local_mode;
			tbs_pkg::remote_command_source: event_hit = remote_trigger;
			tbs_pkg::rear_input_source:     event_hit = rear_fall;
			default:                        event_hit = 1'b0;
		endcase
	end

	// One delay setting for all functions when fixed mode is chosen
	assign dly_load = fixed_delay_mode_r ? delay_ms_r
		: auto_delay(func_r, range_r);

	// A count outside 2..512 blocks arming and initiate
	assign count_valid = (capture_count_r >= tbs_pkg::COUNT_MIN)
		&& (capture_count_r <= tbs_pkg::COUNT_MAX);
	// Initiate write stands for leaving the setup menu
	assign initiate = reg_wr && (reg_addr == tbs_pkg::OFS_CMD)
		&& reg_wdata[tbs_pkg::CMD_INITIATE];
	assign store_en = (state_r == tbs_pkg::ST_MEASURE) && conv_done && capturing_r;
	// Stop at the count even if it is lowered mid-capture; never pass the buffer end
	assign last_store = store_en && (((stored_r + 10'h001) >= capture_count_r)
		|| ((stored_r + 10'h001) >= tbs_pkg::COUNT_MAX));
	// Reading taken as signed for the statistics
	assign rd_s = conv_reading;
	assign rd_sq = rd_s * rd_s;

	// Millisecond divider, restarted at each event
	// Held at zero outside the delay so every counted ms is a whole one
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ms_div_r <= 32'h0000_0000;
		end else if (state_r != tbs_pkg::ST_DELAY || ms_tick) begin
			ms_div_r <= 32'h0000_0000;
		end else begin
			ms_div_r <= ms_div_r + 32'h0000_0001;
		end
	end
	assign ms_tick = (ms_div_r == 32'(CYC_PER_MS - 1));

	// Sequencer state machine
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_r    <= tbs_pkg::ST_IDLE;
			dly_left_r <= 13'h0000;
			meas_start <= 1'b0;
		end else begin
			meas_start <= 1'b0;
			case (state_r)
				tbs_pkg::ST_IDLE: begin
					if (run_r) begin
						state_r <= tbs_pkg::ST_WAIT;
					end
				end
				tbs_pkg::ST_WAIT: begin
					if (!run_r) begin
						state_r <= tbs_pkg::ST_IDLE;
					end else if (event_hit) begin
						if (dly_load == 13'h0000) begin
							state_r    <= tbs_pkg::ST_MEASURE;
							meas_start <= 1'b1;
						end else begin
							state_r    <= tbs_pkg::ST_DELAY;
							dly_left_r <= dly_load;
						end
					end
				end
				tbs_pkg::ST_DELAY: begin
					if (ms_tick) begin
						if (dly_left_r == 13'h0001) begin
							state_r    <= tbs_pkg::ST_MEASURE;
							meas_start <= 1'b1;
						end
						dly_left_r <= dly_left_r - 13'h0001;
					end
				end
				tbs_pkg::ST_MEASURE: begin
					if (conv_done) begin
						state_r <= run_r ? tbs_pkg::ST_WAIT : tbs_pkg::ST_IDLE;
					end
				end
				default: state_r <= tbs_pkg::ST_IDLE;
			endcase
		end
	end

	// Measurement complete pulse
	always_ff @(posedge clk) begin
		if (!nrst) begin
			measure_done_output <= 1'b0;
		end else begin
			measure_done_output <= (state_r == tbs_pkg::ST_MEASURE) && conv_done;
		end
	end

	// Software settings; software set of capture enable beats hardware clear
	always_ff @(posedge clk) begin
		if (!nrst) begin
			src_r                    <= tbs_pkg::immediate_source;
			func_r                   <= tbs_pkg::dc_voltage_function;
			range_r                  <= 3'h0;
			fixed_delay_mode_r       <= 1'b0;
			reading_capture_enable_r <= 1'b0;
			run_r                    <= 1'b0;
			delay_ms_r               <= tbs_pkg::DELAY_RST;
			capture_count_r          <= tbs_pkg::COUNT_RST;
			buf_idx_r                <= '0;
		end else begin
			if (last_store) begin
				reading_capture_enable_r <= 1'b0;
			end
			if (reg_wr) begin
				case (reg_addr)
					tbs_pkg::OFS_CTRL: begin
						src_r   <= tbs_pkg::tbs_src_t'(reg_wdata[tbs_pkg::CTRL_SRC_LSB +: 2]);
						func_r  <= tbs_pkg::tbs_func_t'(reg_wdata[tbs_pkg::CTRL_FUNC_LSB +: 4]);
						range_r <= reg_wdata[tbs_pkg::CTRL_RNG_LSB +: 3];
						fixed_delay_mode_r       <= reg_wdata[tbs_pkg::CTRL_FIXED];
						reading_capture_enable_r <= reg_wdata[tbs_pkg::CTRL_CAP_EN];
						run_r                    <= reg_wdata[tbs_pkg::CTRL_RUN];
					end
					tbs_pkg::OFS_DELAY: begin
						delay_ms_r <= (reg_wdata[31:0] > 32'(tbs_pkg::DELAY_MAX_MS))
							? tbs_pkg::DELAY_MAX_MS : reg_wdata[12:0];
					end
					tbs_pkg::OFS_COUNT:   capture_count_r <= reg_wdata[9:0];
					tbs_pkg::OFS_BUF_IDX: buf_idx_r <= reg_wdata[AW-1:0];
					default: ;
				endcase
			end
		end
	end

	// Capture control and stored count
	always_ff @(posedge clk) begin
		if (!nrst) begin
			capturing_r <= 1'b0;
			stored_r    <= 10'h000;
		end else if (initiate && reading_capture_enable_r && count_valid) begin
			capturing_r <= 1'b1;
			stored_r    <= 10'h000;
		end else if (store_en) begin
			stored_r <= stored_r + 10'h001;
			if (last_store) begin
				capturing_r <= 1'b0;
			end
		end
	end

	// Armed indicator
	always_ff @(posedge clk) begin
		if (!nrst) begin
			capture_armed <= 1'b0;
		end else begin
			capture_armed <= reading_capture_enable_r && count_valid && !last_store;
		end
	end

	// Running statistics over stored readings
	always_ff @(posedge clk) begin
		if (!nrst) begin
			min_r <= '0;
			max_r <= '0;
			sum_r <= 64'h0000_0000_0000_0000;
			sq_r  <= 64'h0000_0000_0000_0000;
		end else if (store_en) begin
			if (stored_r == 10'h000) begin
				min_r <= rd_s;
				max_r <= rd_s;
				sum_r <= 64'(rd_s);
				sq_r  <= 64'(rd_sq);
			end else begin
				if (rd_s < min_r) begin
					min_r <= rd_s;
				end
				if (rd_s > max_r) begin
					max_r <= rd_s;
				end
				sum_r <= sum_r + 64'(rd_s);
				sq_r  <= sq_r + 64'(rd_sq);
			end
		end
	end

	// Reading store, value only
	tbs_buf_mem #(
		.WIDTH (RW),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.clk     (clk),
		.wr_en   (store_en),
		.wr_addr (stored_r[AW-1:0]),
		.wr_data (conv_reading),
		.rd_addr (buf_idx_r),
		.rd_data (buf_rd_data)
	);

	// Register read data, valid only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!nrst || !reg_rd) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			case (reg_addr)
				tbs_pkg::OFS_CTRL: begin
					reg_rdata <= 32'h0000_0000;
					reg_rdata[tbs_pkg::CTRL_SRC_LSB +: 2]  <= src_r;
					reg_rdata[tbs_pkg::CTRL_FIXED]         <= fixed_delay_mode_r;
					reg_rdata[tbs_pkg::CTRL_CAP_EN]        <= reading_capture_enable_r;
					reg_rdata[tbs_pkg::CTRL_FUNC_LSB +: 4] <= func_r;
					reg_rdata[tbs_pkg::CTRL_RNG_LSB +: 3]  <= range_r;
					reg_rdata[tbs_pkg::CTRL_RUN]           <= run_r;
				end
				tbs_pkg::OFS_DELAY:    reg_rdata <= {19'h00000, delay_ms_r};
				tbs_pkg::OFS_COUNT:    reg_rdata <= {22'h000000, capture_count_r};
				// Status: state [1:0], capturing [2], armed [3], stored count [15:6]
				tbs_pkg::OFS_STATUS: begin
					reg_rdata <= {16'h0000, stored_r, 2'b00, capture_armed,
						capturing_r, state_r};
				end
				tbs_pkg::OFS_BUF_IDX:  reg_rdata <= 32'(buf_idx_r);
				tbs_pkg::OFS_BUF_DATA: reg_rdata <= 32'(signed'(buf_rd_data));
				tbs_pkg::OFS_MIN:      reg_rdata <= 32'(min_r);
				tbs_pkg::OFS_MAX:      reg_rdata <= 32'(max_r);
				tbs_pkg::OFS_SUM_LO:   reg_rdata <= sum_r[31:0];
				tbs_pkg::OFS_SUM_HI:   reg_rdata <= sum_r[63:32];
				tbs_pkg::OFS_SQ_LO:    reg_rdata <= sq_r[31:0];
				tbs_pkg::OFS_SQ_HI:    reg_rdata <= sq_r[63:32];
				default:               reg_rdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- pkg/tbs_pkg.sv
// How it works
// - Idle whenever no measurement runs
// - Wait state holds until selected event
// - Four trigger sources selectable
// - Immediate source triggers at once, repeats
// - Front key triggers only in local mode
// - Remote bus trigger command triggers
// - Rear input signal triggers
// - Delay after event, auto or fixed
// - Auto dc voltage delay 1ms/5ms
// - Auto ac voltage/current delay 400ms
// - Auto resistance delay rises with range
// - Fixed delay 0 to 6000 ms
// - Fixed delay mode shared by all functions
// - Pulse done output per measurement
// - Capture count 2 to 512
// - Store until count reached, then stop
// - Each capture restarts at first entry
// - Entries hold reading value only
// - Storage starts on menu exit when armed
// - Armed indicator lit until count stored
// - Capture enable cleared when done
// - Keep min, max, sum, square sums
`default_nettype none
package tbs_pkg;
	// Clock and millisecond timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT_PULSE_NS  = 1000;
	localparam int EXT_PULSE_CYC = (EXT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_DELAY    = 8'h04;
	localparam logic [7:0] OFS_COUNT    = 8'h08;
	localparam logic [7:0] OFS_CMD      = 8'h0C;
	localparam logic [7:0] OFS_STATUS   = 8'h10;
	localparam logic [7:0] OFS_BUF_IDX  = 8'h14;
	localparam logic [7:0] OFS_BUF_DATA = 8'h18;
	localparam logic [7:0] OFS_MIN      = 8'h1C;
	localparam logic [7:0] OFS_MAX      = 8'h20;
	localparam logic [7:0] OFS_SUM_LO   = 8'h24;
	localparam logic [7:0] OFS_SUM_HI   = 8'h28;
	localparam logic [7:0] OFS_SQ_LO    = 8'h2C;
	localparam logic [7:0] OFS_SQ_HI    = 8'h30;

	// Control register field positions
	localparam int CTRL_SRC_LSB  = 0;
	localparam int CTRL_FIXED    = 2;
	localparam int CTRL_CAP_EN   = 3;
	localparam int CTRL_FUNC_LSB = 4;
	localparam int CTRL_RNG_LSB  = 8;
	localparam int CTRL_RUN      = 11;
	localparam int CMD_INITIATE  = 0;

	// Limits and reset values
	localparam logic [12:0] DELAY_MAX_MS = 13'h1770;
	localparam logic [12:0] DELAY_RST    = 13'h0000;
	localparam logic [9:0]  COUNT_MIN    = 10'h002;
	localparam logic [9:0]  COUNT_MAX    = 10'h200;
	localparam logic [9:0]  COUNT_RST    = 10'h000;

	// Automatic delay figures in ms
	localparam logic [12:0] DLY_DCV_LO  = 13'h0001;
	localparam logic [12:0] DLY_DCV_HI  = 13'h0005;
	localparam logic [12:0] DLY_AC      = 13'h0190;
	localparam logic [12:0] DLY_FREQ    = 13'h0001;
	localparam logic [12:0] DLY_DCI     = 13'h0002;
	localparam logic [12:0] DLY_RES_R0  = 13'h0003;
	localparam logic [12:0] DLY_RES_R2  = 13'h000D;
	localparam logic [12:0] DLY_RES_R3  = 13'h0019;
	localparam logic [12:0] DLY_RES_R4  = 13'h0064;
	localparam logic [12:0] DLY_RES_R5  = 13'h0096;
	localparam logic [12:0] DLY_RES_R6  = 13'h00FA;
	localparam logic [12:0] DLY_CONT    = 13'h0003;
	localparam logic [12:0] DLY_DIODE   = 13'h0001;
	localparam logic [2:0]  DCV_HI_RNG  = 3'h3;

	typedef enum logic [1:0] {
		immediate_source      = 2'b00,
		front_key_source      = 2'b01,
		remote_command_source = 2'b10,
		rear_input_source     = 2'b11
	} tbs_src_t;

	typedef enum logic [3:0] {
		dc_voltage_function = 4'b0000,
		ac_voltage_function = 4'b0001,
		frequency_function  = 4'b0010,
		dc_current_function = 4'b0011,
		ac_current_function = 4'b0100,
		res_2wire_function  = 4'b0101,
		res_4wire_function  = 4'b0110,
		continuity_function = 4'b0111,
		diode_function      = 4'b1000
	} tbs_func_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_WAIT    = 2'b01,
		ST_DELAY   = 2'b10,
		ST_MEASURE = 2'b11
	} tbs_state_t;
endpackage
`default_nettype wire

//--- hdl/tbs_buf_mem.sv
`default_nettype none
// Reading store with registered read port
module tbs_buf_mem #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 512,
	parameter int AW    = 9
) (
	input  wire logic             clk,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Write port
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Read port, data one cycle after address
	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

//--- verification/tbs_sequencer_checker.sv
`default_nettype none
// Port-level watch on trigger, delay and capture behaviour
module tbs_checker #(
	parameter int CYC_PER_MS = 4
) (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        front_key_press,
	input wire logic        local_mode,
	input wire logic        remote_trigger,
	input wire logic        rear_trigger_input,
	input wire logic        conv_done,
	input wire logic        meas_start,
	input wire logic        measure_done_output,
	input wire logic        capture_armed
);
	logic [1:0]  src_r;
	logic        fix_r;
	logic [12:0] dly_r;
	logic [9:0]  cnt_r;
	logic        rear_q_r;
	int          ev_age_r;
	int          fall_age_r;
	logic        cnt_ok;
	logic        d0;
	assign cnt_ok = cnt_r >= tbs_pkg::COUNT_MIN && cnt_r <= tbs_pkg::COUNT_MAX;
	assign d0     = fix_r && dly_r == 13'h0000;
	// Shadow copy of the settings written over the bus
	always_ff @(posedge clk) begin
		if (!nrst) begin
			src_r <= 2'h0;
			fix_r <= 1'h0;
			dly_r <= 13'h0000;
			cnt_r <= 10'h000;
		end else if (reg_wr) begin
			if (reg_addr == tbs_pkg::OFS_CTRL) begin
				src_r <= reg_wdata[1:0];
				fix_r <= reg_wdata[2];
			end
			if (reg_addr == tbs_pkg::OFS_DELAY)
				dly_r <= (reg_wdata > 32'(tbs_pkg::DELAY_MAX_MS)) ? tbs_pkg::DELAY_MAX_MS
					: reg_wdata[12:0];
			if (reg_addr == tbs_pkg::OFS_COUNT)
				cnt_r <= reg_wdata[9:0];
		end
	end
	// Cycles since the last bus trigger and the last rear-pin fall
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ev_age_r   <= 0;
			fall_age_r <= 0;
			rear_q_r   <= 1'h1;
		end else begin
			ev_age_r   <= remote_trigger ? 1 : ev_age_r + 32'(ev_age_r < 99999);
			fall_age_r <= (rear_q_r && !rear_trigger_input) ? 1 : fall_age_r + 32'(fall_age_r < 99);
			rear_q_r   <= rear_trigger_input;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_done_follows: assert property (measure_done_output |-> $past(conv_done))
		else $error("done pulse without converter finish");
	a_done_single: assert property (not (measure_done_output ##1 measure_done_output))
		else $error("done pulse longer than one cycle");
	a_start_single: assert property ($rose(meas_start) |=> $fell(meas_start))
		else $error("start pulse longer than one cycle");
	a_key_local: assert property (src_r == tbs_pkg::front_key_source && d0
		&& !(front_key_press && local_mode) |=> !meas_start)
		else $error("start without a local key press");
	a_remote_only: assert property (src_r == tbs_pkg::remote_command_source && d0
		&& !remote_trigger |=> !meas_start)
		else $error("start without a bus trigger");
	a_rear_sync: assert property (meas_start && src_r == tbs_pkg::rear_input_source
		&& d0 |-> fall_age_r >= 1 && fall_age_r <= 8)
		else $error("rear start not tied to a falling edge");
	a_fixed_delay: assert property (meas_start && fix_r
		&& src_r == tbs_pkg::remote_command_source
		|-> ev_age_r >= int'(dly_r) * CYC_PER_MS && ev_age_r <= int'(dly_r) * CYC_PER_MS + 3)
		else $error("fixed delay length wrong");
	a_armed_count: assert property (capture_armed
		|-> cnt_ok || $past(cnt_ok) || $past(cnt_ok, 2))
		else $error("armed with invalid count");
endmodule
bind tbs_sequencer tbs_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
	.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.front_key_press(front_key_press), .local_mode(local_mode), .remote_trigger(remote_trigger),
	.rear_trigger_input(rear_trigger_input), .conv_done(conv_done), .meas_start(meas_start),
	.measure_done_output(measure_done_output), .capture_armed(capture_armed)
);
`default_nettype wire

//--- verification/tbs_far_model.sv
`default_nettype none
// Far side: rear trigger source, remote host and converter
module tbs_far_model (
	input  wire logic   clk,
	input  wire logic   meas_start,
	output logic        rear_trigger_input,
	output logic        remote_trigger,
	output logic        conv_done,
	output logic [23:0] conv_reading
);
	timeunit 1ns;
	timeprecision 1ps;
	int          lat = 1;
	logic [23:0] next_rd = 24'h000000;
	initial begin
		rear_trigger_input = 1'h1;
		remote_trigger = 1'h0;
		conv_done = 1'h0;
		conv_reading = 24'h000000;
	end
	// Converter answers each start once after lat cycles, then scrambles its data
	always @(posedge clk) begin
		if (meas_start) begin
			repeat (lat) @(posedge clk);
			conv_done <= 1'h1;
			conv_reading <= next_rd;
			@(posedge clk);
			conv_done <= 1'h0;
			conv_reading <= ~next_rd;
		end
	end
	// Low pulse on the rear pin, wider than the minimum
	task automatic rear_pulse(input int w);
		@(posedge clk);
		rear_trigger_input <= 1'h0;
		repeat (w) @(posedge clk);
		rear_trigger_input <= 1'h1;
	endtask
	// One-cycle bus trigger command
	task automatic remote_cmd();
		@(posedge clk);
		remote_trigger <= 1'h1;
		@(posedge clk);
		remote_trigger <= 1'h0;
	endtask
endmodule
`default_nettype wire

//--- verification/trigger_buffer_sequencer_tb.sv
`default_nettype none
// Self-checking bench for the trigger and capture sequencer
module trigger_buffer_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CYC = 4;
	logic        clk = 1'h0;
	logic        nrst = 1'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic        key = 1'h0;
	logic        local_mode = 1'h0;
	logic [31:0] reg_rdata;
	logic        rt, rear, cd, ms, md, arm;
	logic [23:0] crd, r;
	logic [31:0] ex[$];
	longint      x, mn, mx, sm, sq;
	int          err_total = 0;
	int          cmp_count = 0;
	int          n, k;
	int          t_fn[] = '{0, 0, 0, 0, 1, 1, 4, 4, 5, 5, 5, 5, 5, 5, 5, 6, 1, 5};
	int          t_rg[] = '{0, 2, 3, 4, 0, 4, 0, 2, 0, 1, 2, 3, 4, 5, 6, 2, 0, 6};
	int          t_ms[] = '{1, 1, 5, 5, 400, 400, 400, 400, 3, 3, 13, 25, 100, 150, 250, 13, 2, 2};
	int          c_val[] = '{0, 1, 2, 512, 513};
	int          c_ok[] = '{0, 0, 1, 1, 0};
	always #12.5 clk = ~clk;
	tbs_sequencer #(.CYC_PER_MS(CYC)) u_dut (
		.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .front_key_press(key), .local_mode(local_mode),
		.remote_trigger(rt), .rear_trigger_input(rear), .conv_done(cd), .conv_reading(crd),
		.meas_start(ms), .measure_done_output(md), .capture_armed(arm)
	);
	tbs_far_model u_far (.clk(clk), .meas_start(ms), .rear_trigger_input(rear),
		.remote_trigger(rt), .conv_done(cd), .conv_reading(crd));
	// Compare, count and report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Register bus cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		check(reg_rdata, e);
	endtask
	function automatic logic [31:0] ctrl(input int s, fx, cap, fn, rg);
		return {20'h0, 1'h1, rg[2:0], fn[3:0], cap[0], fx[0], s[1:0]};
	endfunction
	// Event of a source; bounded waits for start and done
	task automatic fire(input int s);
		if (s == 1) begin
			@(posedge clk);
			key <= 1'h1;
			@(posedge clk);
			key <= 1'h0;
		end else if (s == 2)
			u_far.remote_cmd();
		else
			fork
				u_far.rear_pulse(tbs_pkg::EXT_PULSE_CYC + 1);
			join_none
	endtask
	task automatic wait_start(input int lim, input bit must);
		for (n = 1; n <= lim; n++) begin
			#1;
			if (ms)
				return;
			@(posedge clk);
		end
		n = 0;
		if (must) begin
			err_total++;
			end_sim();
		end
	endtask
	task automatic wait_done();
		repeat (100) begin
			@(posedge clk);
			#1;
			if (md)
				return;
		end
		err_total++;
		end_sim();
	endtask
	initial begin
		void'($urandom(67214));
		repeat (6) @(posedge clk);
		nrst <= 1'h1;
		rdc(tbs_pkg::OFS_STATUS, 32'h0);
		rdc(tbs_pkg::OFS_COUNT, 32'h0);
		wr(tbs_pkg::OFS_DELAY, 32'h1FFF);
		rdc(tbs_pkg::OFS_DELAY, 32'h1770);
		wr(tbs_pkg::OFS_DELAY, 32'h0);
		// Key press outside local mode, then the key, remote and rear sources with zero delay
		wr(tbs_pkg::OFS_CTRL, ctrl(1, 1, 0, 0, 0));
		fire(1);
		wait_start(10, 1'b0);
		check(32'(n), 32'h0);
		local_mode <= 1'h1;
		for (int s = 1; s < 4; s++) begin
			wr(tbs_pkg::OFS_CTRL, ctrl(s, 1, 0, 0, 0));
			fire(s);
			wait_start(12, 1'b1);
			check(32'(n), (s == 3) ? 32'h5 : 32'h1);
			wait_done();
			repeat (50) @(posedge clk);
		end
		// Immediate source repeats on its own
		wr(tbs_pkg::OFS_CTRL, ctrl(0, 1, 0, 0, 0));
		k = 0;
		repeat (200) begin
			@(posedge clk);
			#1;
			k += int'(ms);
		end
		wr(tbs_pkg::OFS_CTRL, 32'h0);
		check(32'(k >= 3), 32'h1);
		repeat (50) @(posedge clk);
		// Automatic delay table, then fixed delay shared by functions
		wr(tbs_pkg::OFS_DELAY, 32'h2);
		u_far.lat = 20;
		foreach (t_ms[i]) begin
			wr(tbs_pkg::OFS_CTRL, ctrl(2, int'(i > 15), 0, t_fn[i], t_rg[i]));
			u_far.remote_cmd();
			wait_start(2000, 1'b1);
			check(32'(n >= t_ms[i] * CYC && n <= t_ms[i] * CYC + 3), 32'h1);
			wait_done();
		end
		u_far.lat = 1;
		wr(tbs_pkg::OFS_DELAY, 32'h0);
		// Two captures; the second overwrites from entry 0
		for (int p = 3; p > 1; p--) begin
			wr(tbs_pkg::OFS_COUNT, 32'(p));
			wr(tbs_pkg::OFS_CTRL, ctrl(2, 1, 1, 0, 0));
			wr(tbs_pkg::OFS_CMD, 32'h1);
			rdc(tbs_pkg::OFS_STATUS, 32'hD);
			ex.delete();
			for (int i = 0; i <= p; i++) begin
				r = 24'($urandom);
				if (i < p)
					ex.push_back({{8{r[23]}}, r});
				u_far.next_rd <= r;
				u_far.remote_cmd();
				wait_start(12, 1'b1);
				wait_done();
				repeat (2) @(posedge clk);
				#1;
				check(32'(arm), 32'(i < p - 1));
			end
			rdc(tbs_pkg::OFS_STATUS, 32'((p << 6) | 1));
			rdc(tbs_pkg::OFS_CTRL, ctrl(2, 1, 0, 0, 0));
			mn = 64'sd1 << 40;
			mx = -mn;
			sm = 0;
			sq = 0;
			foreach (ex[i]) begin
				x = $signed(ex[i]);
				sm += x;
				sq += x * x;
				mn = (x < mn) ? x : mn;
				mx = (x > mx) ? x : mx;
				wr(tbs_pkg::OFS_BUF_IDX, 32'(i));
				@(posedge clk);
				rdc(tbs_pkg::OFS_BUF_DATA, ex[i]);
			end
			rdc(tbs_pkg::OFS_MIN, mn[31:0]);
			rdc(tbs_pkg::OFS_MAX, mx[31:0]);
			rdc(tbs_pkg::OFS_SUM_LO, sm[31:0]);
			rdc(tbs_pkg::OFS_SUM_HI, sm[63:32]);
			rdc(tbs_pkg::OFS_SQ_LO, sq[31:0]);
			rdc(tbs_pkg::OFS_SQ_HI, sq[63:32]);
		end
		// Count limits gate the armed indicator and the initiate command
		wr(tbs_pkg::OFS_CTRL, ctrl(2, 1, 1, 0, 0));
		foreach (c_val[i]) begin
			wr(tbs_pkg::OFS_COUNT, 32'(c_val[i]));
			repeat (3) @(posedge clk);
			#1;
			check(32'(arm), 32'(c_ok[i]));
		end
		wr(tbs_pkg::OFS_CMD, 32'h1);
		rdc(tbs_pkg::OFS_STATUS, 32'((2 << 6) | 1));
		end_sim();
	end
endmodule
`default_nettype wire
